// ### bdc_defines.svh
`ifndef BDC_DEFINES_SVH
`define BDC_DEFINES_SVH

// register indices; the byte address is four times the index
`define BDC_IDX_HIGH      3'h0
`define BDC_IDX_LOW       3'h1
`define BDC_IDX_CTRL      3'h2
`define BDC_IDX_EVT_STAT  3'h3
`define BDC_IDX_EVT_CLR   3'h4
`define BDC_IDX_EVT_EN    3'h5
`define BDC_IDX_LAST      3'h5

// fields of the high register
`define BDC_HI_BRK_IE     7
`define BDC_HI_EDGE_IE    6
`define BDC_HI_STOP2      5
`define BDC_HI_DIV_MSB    4

// fields of the control register
`define BDC_CTRL_RE       0
`define BDC_CTRL_TE       1

// event bits
`define BDC_EVT_BRK       0
`define BDC_EVT_EDGE      1
`define BDC_EVT_LOAD      2
`define BDC_EVT_W         3

// reset values
`define BDC_HIGH_RST      8'h00
`define BDC_LOW_RST       8'h04
`define BDC_DIV_RST       13'h0004

// documented divisor width and oversampling ratio
`define BDC_DIV_W         13
`define BDC_OVS           16

`endif

// ### bdc_pkg.sv
package bdc_pkg;
  typedef logic [2:0] bdc_idx_t;
  typedef logic [7:0] bdc_byte_t;
  typedef logic [2:0] bdc_evt_t;
endpackage : bdc_pkg

// ### bdc_gen_if.sv
`timescale 1ns/1ps
interface bdc_gen_if #(
  parameter int DIV_W = 13
);
  logic [DIV_W-1:0] divisor;
  logic             run;
  logic             sample_tick;
  logic             bit_tick;

  modport ctrl (output divisor, output run, input sample_tick, input bit_tick);
  modport gen  (input divisor, input run, output sample_tick, output bit_tick);
endinterface : bdc_gen_if

// ### bdc_rate_gen.sv
`timescale 1ns/1ps
`include "bdc_defines.svh"
module bdc_rate_gen
  import bdc_pkg::*;
#(
  parameter int DIV_W = `BDC_DIV_W,
  parameter int OVS   = `BDC_OVS
) (
  input  wire logic pclk,
  input  wire logic presetn,
  bdc_gen_if.gen    gi
);
  localparam int OS_W = $clog2(OVS);

  if (OVS < 2 || (1 << OS_W) != OVS) begin : g_chk
    $error("oversampling ratio must be a power of two of at least 2");
  end

  logic [DIV_W-1:0] pre_q;
  logic [OS_W-1:0]  os_q;
  logic             st_q;
  logic             bt_q;
  logic             pre_wrap;

  // prescaler wraps at divisor-1; also catches a divisor lowered under it
  assign pre_wrap = (pre_q >= gi.divisor - DIV_W'(1));

  // prescaler: one sample tick per divisor bus clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
      st_q  <= 1'b0;
    end else if (!gi.run) begin
      pre_q <= '0;
      st_q  <= 1'b0;
    end else begin
      st_q  <= pre_wrap;
      pre_q <= pre_wrap ? '0 : pre_q + DIV_W'(1);
    end
  end

  // oversampling counter: one bit tick per sixteen sample ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      os_q <= '0;
      bt_q <= 1'b0;
    end else if (!gi.run) begin
      os_q <= '0;
      bt_q <= 1'b0;
    end else begin
      bt_q <= pre_wrap && (os_q == OS_W'(OVS - 1));
      if (pre_wrap) begin
        os_q <= os_q + OS_W'(1);
      end
    end
  end

  assign gi.sample_tick = st_q;
  assign gi.bit_tick    = bt_q;

  // helper: cycles since last bit tick, and whether divisor held steady
  logic [DIV_W+OS_W:0] gap_q;
  logic                steady_q;
  logic [DIV_W-1:0]    div_seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q      <= '0;
      steady_q   <= 1'b0;
      div_seen_q <= '0;
    end else begin
      div_seen_q <= gi.divisor;
      if (!gi.run) begin
        gap_q    <= '0;
        steady_q <= 1'b0;
      end else if (bt_q) begin
        gap_q    <= (DIV_W+OS_W+1)'(1);
        steady_q <= 1'b1;
      end else begin
        gap_q    <= gap_q + (DIV_W+OS_W+1)'(1);
        steady_q <= steady_q && (div_seen_q == gi.divisor);
      end
    end
  end

  property p_rate_period;
    @(posedge pclk) disable iff (!presetn)
      (bt_q && steady_q && gi.run && div_seen_q == gi.divisor)
      |-> (gap_q == (DIV_W+OS_W+1)'(OVS) * (DIV_W+OS_W+1)'(gi.divisor));
  endproperty
  a_rate_period: assert property (p_rate_period)
    else $error("bit tick period is not sixteen times the divisor");

  property p_gen_idle;
    @(posedge pclk) disable iff (!presetn)
      !gi.run |=> (!gi.sample_tick && !gi.bit_tick && pre_q == '0);
  endproperty
  a_gen_idle: assert property (p_gen_idle)
    else $error("rate generator toggles while stopped");

endmodule : bdc_rate_gen

// ### bdc_baud_cfg.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "bdc_defines.svh"
// Notes on behaviour
// - high byte first; its divisor part waits until the low byte write loads all 13 bits.
// - with the break-detect enable set the break-detect flag raises an interrupt, otherwise only via its sticky event when its event enable is set.
// - with the rx-edge enable set the rx-edge flag raises an interrupt, otherwise only via its sticky event when its event enable is set.
// - the stop-bit select gives one stop bit when 0 and two when 1.
// - a divisor of zero stops the bit-rate generator completely.
// - for divisors 1 to 8191 the bit rate is the bus clock over sixteen times the divisor.
// - after reset the generator stays idle until receive or transmit enable is first set to 1.
module bdc_baud_cfg
  import bdc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DIV_W  = `BDC_DIV_W
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              break_detect_flag,
  input  wire logic              rx_edge_flag,
  output logic                   receive_enable,
  output logic                   transmit_enable,
  output logic                   stop_bit_count_select,
  output logic                   sample_tick,
  output logic                   bit_tick,
  output logic                   gen_running,
  output logic                   irq
);

  if (DIV_W != `BDC_DIV_W) begin : g_chk
    $error("divisor width must match the 13-bit register layout");
  end
  if (ADDR_W < 5) begin : g_chk_addr
    $error("address width too small for the register map");
  end

  // reset images of the two divisor registers, sliced per field below
  localparam bdc_byte_t        HIGH_RST = `BDC_HIGH_RST;
  localparam logic [DIV_W-1:0] DIV_RST  = `BDC_DIV_RST;

  bdc_gen_if #(.DIV_W(DIV_W)) gi ();

  bdc_rate_gen #(
    .DIV_W (DIV_W),
    .OVS   (`BDC_OVS)
  ) u_gen (
    .pclk    (pclk),
    .presetn (presetn),
    .gi      (gi)
  );

  // decode helpers
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[1:0] == 2'b00) && (a[ADDR_W-1:5] == '0)
              && (a[4:2] <= `BDC_IDX_LAST);
  endfunction : addr_ok

  function automatic bdc_idx_t addr_idx(input logic [ADDR_W-1:0] a);
    addr_idx = a[4:2];
  endfunction : addr_idx

  logic      setup_ph;
  logic      access_ph;
  logic      wr_en;
  logic      hit;
  bdc_idx_t  idx;
  bdc_byte_t wbyte;

  // apb phase decode; the slave never inserts wait states
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign hit       = addr_ok(paddr);
  assign idx       = addr_idx(paddr);
  assign wbyte     = pwdata[7:0];
  assign wr_en     = access_ph && pwrite && hit;
  assign pready    = access_ph;
  assign pslverr   = access_ph && !hit;

  logic            wr_high;
  logic            wr_low;
  logic            wr_ctrl;
  logic            wr_clr;
  logic            wr_en_evt;
  assign wr_high   = wr_en && (idx == `BDC_IDX_HIGH);
  assign wr_low    = wr_en && (idx == `BDC_IDX_LOW);
  assign wr_ctrl   = wr_en && (idx == `BDC_IDX_CTRL);
  assign wr_clr    = wr_en && (idx == `BDC_IDX_EVT_CLR);
  assign wr_en_evt = wr_en && (idx == `BDC_IDX_EVT_EN);

  // high register: option bits act at once, divisor part is only staged
  logic                     brk_ie_q;
  logic                     edge_ie_q;
  logic                     stop2_q;
  logic [`BDC_HI_DIV_MSB:0] div_hi_buf_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_ie_q     <= HIGH_RST[`BDC_HI_BRK_IE];
      edge_ie_q    <= HIGH_RST[`BDC_HI_EDGE_IE];
      stop2_q      <= HIGH_RST[`BDC_HI_STOP2];
      div_hi_buf_q <= DIV_RST[DIV_W-1:8];
    end else if (wr_high) begin
      brk_ie_q     <= wbyte[`BDC_HI_BRK_IE];
      edge_ie_q    <= wbyte[`BDC_HI_EDGE_IE];
      stop2_q      <= wbyte[`BDC_HI_STOP2];
      div_hi_buf_q <= wbyte[`BDC_HI_DIV_MSB:0];
    end
  end

  // working divisor: loaded whole on a low byte write
  logic [DIV_W-1:0] div_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= DIV_RST;
    end else if (wr_low) begin
      div_q <= {div_hi_buf_q, wbyte};
    end
  end

  // receive and transmit enables
  logic re_q;
  logic te_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      re_q <= 1'b0;
      te_q <= 1'b0;
    end else if (wr_ctrl) begin
      re_q <= wbyte[`BDC_CTRL_RE];
      te_q <= wbyte[`BDC_CTRL_TE];
    end
  end

  // generator armed at the first enable of either direction, then stays armed
  logic armed_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (wr_ctrl && (wbyte[`BDC_CTRL_RE] || wbyte[`BDC_CTRL_TE])) begin
      armed_q <= 1'b1;
    end
  end

  // generator runs only when armed and the divisor is nonzero
  assign gi.divisor = div_q;
  assign gi.run     = armed_q && (div_q != '0);

  // rising edges of the flags and divisor loads are sticky events
  logic     brk_prev_q;
  logic     edge_prev_q;
  bdc_evt_t evt_set;
  bdc_evt_t evt_stat_q;
  bdc_evt_t evt_en_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_prev_q  <= 1'b0;
      edge_prev_q <= 1'b0;
    end else begin
      brk_prev_q  <= break_detect_flag;
      edge_prev_q <= rx_edge_flag;
    end
  end

  always_comb begin
    evt_set                = '0;
    evt_set[`BDC_EVT_BRK]  = break_detect_flag && !brk_prev_q;
    evt_set[`BDC_EVT_EDGE] = rx_edge_flag && !edge_prev_q;
    evt_set[`BDC_EVT_LOAD] = wr_low;
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_stat_q <= '0;
    end else begin
      evt_stat_q <= (evt_stat_q & ~(wr_clr ? wbyte[`BDC_EVT_W-1:0] : '0)) | evt_set;
    end
  end

  // event interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_en_q <= '0;
    end else if (wr_en_evt) begin
      evt_en_q <= wbyte[`BDC_EVT_W-1:0];
    end
  end

  // interrupt: live flags gated by the high register enables, plus sticky events
  assign irq = (brk_ie_q && break_detect_flag)
             || (edge_ie_q && rx_edge_flag)
             || |(evt_stat_q & evt_en_q);

  // read mux; data is captured in the setup phase so prdata is a flop
  function automatic bdc_byte_t rd_val(input bdc_idx_t i);
    unique case (i)
      `BDC_IDX_HIGH:     rd_val = {brk_ie_q, edge_ie_q, stop2_q, div_hi_buf_q};
      `BDC_IDX_LOW:      rd_val = div_q[7:0];
      `BDC_IDX_CTRL:     rd_val = {6'h00, te_q, re_q};
      `BDC_IDX_EVT_STAT: rd_val = {5'h00, evt_stat_q};
      `BDC_IDX_EVT_EN:   rd_val = {5'h00, evt_en_q};
      default:           rd_val = 8'h00; // clear register and holes read zero
    endcase
  endfunction : rd_val

  logic [31:0] prdata_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup_ph && !pwrite) begin
      prdata_q <= hit ? {24'h000000, rd_val(idx)} : 32'h00000000;
    end
  end

  assign prdata                = prdata_q;
  assign receive_enable        = re_q;
  assign transmit_enable       = te_q;
  assign stop_bit_count_select = stop2_q;
  assign sample_tick           = gi.sample_tick;
  assign bit_tick              = gi.bit_tick;
  assign gen_running           = gi.run;

  // assertions
  sequence s_wr_high;
    wr_high;
  endsequence

  sequence s_wr_low;
    wr_low;
  endsequence

  sequence s_arm;
    wr_ctrl && (wbyte[`BDC_CTRL_RE] || wbyte[`BDC_CTRL_TE]);
  endsequence

  property p_high_staged;
    @(posedge pclk) disable iff (!presetn)
      s_wr_high ##0 !wr_low |=> (div_q == $past(div_q));
  endproperty
  a_high_staged: assert property (p_high_staged)
    else $error("high byte write changed the working divisor");

  property p_low_loads;
    @(posedge pclk) disable iff (!presetn)
      s_wr_low
      |=> (div_q[DIV_W-1:8] == $past(div_hi_buf_q)
           && div_q[7:0] == $past(pwdata[7:0]));
  endproperty
  a_low_loads: assert property (p_low_loads)
    else $error("low byte write did not load the staged divisor");

  property p_brk_irq;
    @(posedge pclk) disable iff (!presetn)
      (brk_ie_q && break_detect_flag) |-> irq;
  endproperty
  a_brk_irq: assert property (p_brk_irq)
    else $error("break flag with enable set gave no interrupt");

  property p_edge_irq;
    @(posedge pclk) disable iff (!presetn)
      (edge_ie_q && rx_edge_flag) |-> irq;
  endproperty
  a_edge_irq: assert property (p_edge_irq)
    else $error("edge flag with enable set gave no interrupt");

  property p_irq_cause;
    @(posedge pclk) disable iff (!presetn)
      irq |-> ((brk_ie_q && break_detect_flag) || (edge_ie_q && rx_edge_flag)
               || (evt_stat_q & evt_en_q) != '0);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without an enabled cause");

  property p_stop_sel;
    @(posedge pclk) disable iff (!presetn)
      s_wr_high |=> (stop_bit_count_select == $past(pwdata[`BDC_HI_STOP2]));
  endproperty
  a_stop_sel: assert property (p_stop_sel)
    else $error("stop-bit select does not follow the high register");

  property p_zero_stops;
    @(posedge pclk) disable iff (!presetn)
      (div_q == '0) |-> !gen_running ##1 !bit_tick;
  endproperty
  a_zero_stops: assert property (p_zero_stops)
    else $error("generator runs with a zero divisor");

  property p_idle_till_enable;
    @(posedge pclk) disable iff (!presetn)
      !armed_q |-> !gen_running ##1 (!sample_tick || armed_q);
  endproperty
  a_idle_till_enable: assert property (p_idle_till_enable)
    else $error("generator ran before any enable was written");

  property p_arm_starts;
    @(posedge pclk) disable iff (!presetn)
      s_arm ##0 (div_q != '0 && !wr_low) |=> gen_running;
  endproperty
  a_arm_starts: assert property (p_arm_starts)
    else $error("enable write with nonzero divisor did not start generator");

  property p_stage_held;
    @(posedge pclk) disable iff (!presetn)
      !wr_high |=> $stable(div_hi_buf_q);
  endproperty
  a_stage_held: assert property (p_stage_held)
    else $error("staged divisor high part changed without a high write");

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
      (evt_set != '0) |=> ((evt_stat_q & $past(evt_set)) == $past(evt_set));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost to a clear in the same cycle");

  property p_status_sticky;
    @(posedge pclk) disable iff (!presetn)
      !wr_clr |=> ((evt_stat_q & $past(evt_stat_q)) == $past(evt_stat_q));
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("status bit dropped without a clear");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
      (access_ph && !hit) |-> (pslverr && !wr_high && !wr_low && !wr_ctrl);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  property p_prdata_hold;
    @(posedge pclk) disable iff (!presetn)
      !(setup_ph && !pwrite) |=> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold)
    else $error("read data moved outside a read setup");

  property p_bit_on_sample;
    @(posedge pclk) disable iff (!presetn)
      bit_tick |-> sample_tick;
  endproperty
  a_bit_on_sample: assert property (p_bit_on_sample)
    else $error("bit tick without a sample tick");

  property p_arm_sticky;
    @(posedge pclk) disable iff (!presetn)
      armed_q |=> armed_q;
  endproperty
  a_arm_sticky: assert property (p_arm_sticky)
    else $error("generator disarmed without reset");

endmodule : bdc_baud_cfg

// ### tb.sv
`timescale 1ns/1ps
module tb
  import bdc_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        break_detect_flag;
  logic        rx_edge_flag;
  logic        receive_enable;
  logic        transmit_enable;
  logic        stop_bit_count_select;
  logic        sample_tick;
  logic        bit_tick;
  logic        gen_running;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          bad_count;
  int          checks;
  int          i;

  // register byte addresses
  localparam logic [11:0] A_HIGH = 12'h000;
  localparam logic [11:0] A_LOW  = 12'h004;
  localparam logic [11:0] A_CTRL = 12'h008;
  localparam logic [11:0] A_STAT = 12'h00C;
  localparam logic [11:0] A_CLR  = 12'h010;
  localparam logic [11:0] A_EN   = 12'h014;
  localparam logic [11:0] A_NONE = 12'h018;

  bdc_baud_cfg #(.ADDR_W(12)) dut (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .prdata                (prdata),
    .pready                (pready),
    .pslverr               (pslverr),
    .break_detect_flag     (break_detect_flag),
    .rx_edge_flag          (rx_edge_flag),
    .receive_enable        (receive_enable),
    .transmit_enable       (transmit_enable),
    .stop_bit_count_select (stop_bit_count_select),
    .sample_tick           (sample_tick),
    .bit_tick              (bit_tick),
    .gen_running           (gen_running),
    .irq                   (irq)
  );

  // free-running bus clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic conclude();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  // one apb transfer, request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      $display("ERROR %0t no pready", $time);
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk_val(rd, exp, what);
  endtask : rdc

  // cycles between pulses, skipping the first two, possibly transitional, intervals
  task automatic gap(input bit bt, input int exp, input string what);
    int n;
    int k;
    n = 0;
    for (k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (((bt ? bit_tick : sample_tick) !== 1'b1) && n < 20000);
    end
    chk_val(32'(n), 32'(exp), what);
  endtask : gap

  // no tick may appear for 40 cycles
  task automatic quiet(input string what);
    int k;
    int seen;
    seen = 0;
    for (k = 0; k < 40; k++) begin
      @(posedge pclk);
      if (sample_tick === 1'b1 || bit_tick === 1'b1) seen++;
    end
    chk_val(32'(seen), 32'h0, what);
  endtask : quiet

  // watchdog, well beyond the expected run of about 30k cycles
  initial begin
    #5_000_000;
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end

  // main test sequence
  initial begin
    bad_count         = 0;
    checks            = 0;
    presetn           = 1'b0;
    psel              = 1'b0;
    penable           = 1'b0;
    pwrite            = 1'b0;
    paddr             = 12'h000;
    pwdata            = 32'h0000_0000;
    break_detect_flag = 1'b0;
    rx_edge_flag      = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);

    rdc(A_HIGH, 32'h0000_0000, "high reset");
    rdc(A_LOW, 32'h0000_0004, "low reset");
    rdc(A_EN, 32'h0000_0000, "enable reset");
    chk_bit(gen_running, 1'b0, "idle after reset");
    quiet("ticks after reset");
    $display("test reset done");

    apb(1'b1, A_CTRL, 32'h0000_0003);
    chk_bit(receive_enable & transmit_enable, 1'b1, "enables");
    chk_bit(gen_running, 1'b1, "armed");
    gap(1'b0, 4, "sample period 4");
    gap(1'b1, 64, "bit period 4");
    $display("test arm done");

    apb(1'b1, A_HIGH, 32'h0000_0001);
    rdc(A_HIGH, 32'h0000_0001, "staged high");
    gap(1'b0, 4, "high alone keeps divisor");
    apb(1'b1, A_LOW, 32'h0000_0000);
    gap(1'b0, 256, "divisor 256");
    apb(1'b1, A_HIGH, 32'h0000_001F);
    apb(1'b1, A_LOW, 32'h0000_00FF);
    gap(1'b0, 8191, "divisor 8191");
    apb(1'b1, A_HIGH, 32'h0000_0000);
    apb(1'b1, A_LOW, 32'h0000_0001);
    gap(1'b1, 16, "bit period 1");
    apb(1'b1, A_LOW, 32'h0000_0003);
    gap(1'b0, 3, "sample period 3");
    gap(1'b1, 48, "bit period 3");
    $display("test divisor done");

    apb(1'b1, A_LOW, 32'h0000_0000);
    chk_bit(gen_running, 1'b0, "zero divisor");
    quiet("ticks at zero");
    apb(1'b1, A_LOW, 32'h0000_0002);
    chk_bit(gen_running, 1'b1, "restart");
    gap(1'b0, 2, "sample period 2");
    $display("test zero done");

    apb(1'b1, A_HIGH, 32'h0000_0020);
    chk_bit(stop_bit_count_select, 1'b1, "two stop bits");
    apb(1'b1, A_HIGH, 32'h0000_0000);
    chk_bit(stop_bit_count_select, 1'b0, "one stop bit");
    $display("test stop done");

    // each flag with its enable clear, then set, then the flag dropped
    apb(1'b1, A_CLR, 32'h0000_0007);
    for (i = 0; i < 2; i++) begin
      if (i == 0) break_detect_flag <= 1'b1;
      else rx_edge_flag <= 1'b1;
      repeat (2) @(posedge pclk);
      chk_bit(irq, 1'b0, "flag masked");
      apb(1'b1, A_HIGH, 32'h0000_0080 >> i);
      chk_bit(irq, 1'b1, "flag enabled");
      break_detect_flag <= 1'b0;
      rx_edge_flag      <= 1'b0;
      repeat (2) @(posedge pclk);
      chk_bit(irq, 1'b0, "flag dropped");
      apb(1'b1, A_HIGH, 32'h0000_0000);
    end
    $display("test flags done");

    // sticky status through the enable register, then cleared
    apb(1'b1, A_CLR, 32'h0000_0007);
    rdc(A_STAT, 32'h0000_0000, "status cleared");
    apb(1'b1, A_EN, 32'h0000_0001);
    break_detect_flag <= 1'b1;
    repeat (2) @(posedge pclk);
    break_detect_flag <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_bit(irq, 1'b1, "sticky event");
    rdc(A_STAT, 32'h0000_0001, "status break");
    apb(1'b1, A_STAT, 32'h0000_0000);
    rdc(A_STAT, 32'h0000_0001, "status read only");
    apb(1'b1, A_CLR, 32'h0000_0001);
    chk_bit(irq, 1'b0, "event cleared");
    apb(1'b1, A_EN, 32'h0000_0004);
    apb(1'b1, A_LOW, 32'h0000_0002);
    chk_bit(irq, 1'b1, "load event");
    rdc(A_STAT, 32'h0000_0004, "status load");
    chk_bit(err, 1'b0, "mapped no error");
    apb(1'b1, A_CLR, 32'h0000_0004);
    rdc(A_NONE, 32'h0000_0000, "unmapped read");
    chk_bit(err, 1'b1, "unmapped error");
    $display("test events done");

    // second reset in mid-run, then arming by the transmit enable alone
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_bit(gen_running, 1'b0, "idle after second reset");
    rdc(A_LOW, 32'h0000_0004, "low after second reset");
    apb(1'b1, A_CTRL, 32'h0000_0002);
    chk_bit(transmit_enable & !receive_enable, 1'b1, "transmit only");
    chk_bit(gen_running, 1'b1, "armed by transmit");
    gap(1'b1, 64, "bit period after second reset");
    $display("test second reset done");
    conclude();
  end
endmodule : tb
